// File: ldmc_assertions.sv
`timescale 1ns/100ps
// Port checks of the config bank; all outputs are registered, so effects land one edge late
module ldmc_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ser1_irq,
	input wire logic        ser2_irq,
	input wire logic        ser1_pin_assigned,
	input wire logic        ser1_irq_out,
	input wire logic        ser2_irq_out,
	input wire logic        drive_one_on_printer_pins,
	input wire logic        both_drives_on_printer_pins,
	input wire logic        ir_half_duplex,
	input wire logic        ir_tx_busy,
	input wire logic        ir_rx_data
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Zero-wait slave: a setup is always answered in the next cycle, for one cycle only
	setup_answered_a: assert property (psel && !penable |=> pready) else $error("pready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
	ready_cause_a: assert property ($rose(pready) |-> $past(psel) && !$past(penable)) else $error("pready without setup");
	bad_addr_a: assert property (psel && !penable && (paddr > 12'h00C || paddr[1:0] != 2'h0) |=> pslverr)
		else $error("no error for unmapped address");
	good_addr_a: assert property (psel && !penable && paddr <= 12'h00C && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("error on mapped address");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr outside access");
	rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("read data upper bits set");
	irq_quiet_a: assert property (!ser1_irq && !ser2_irq |=> !ser1_irq_out && !ser2_irq_out)
		else $error("serial irq without cause");
	irq_own_a: assert property (ser1_irq && ser1_pin_assigned |=> ser1_irq_out)
		else $error("serial one irq lost");
	route_excl_a: assert property (!(drive_one_on_printer_pins && both_drives_on_printer_pins))
		else $error("two floppy routings at once");
	rx_blank_a: assert property ((ir_half_duplex && ir_tx_busy) [*2] |=> !ir_rx_data)
		else $error("receive open while transmitting");

	// Main scenarios reached
	cover property (pready && pslverr);
	cover property (ser2_irq && !ser1_irq ##1 ser1_irq_out);
	cover property (ir_half_duplex && ir_tx_busy);
endmodule

bind ldmc_top ldmc_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
	.ser1_irq, .ser2_irq, .ser1_pin_assigned, .ser1_irq_out, .ser2_irq_out, .drive_one_on_printer_pins,
	.both_drives_on_printer_pins, .ir_half_duplex, .ir_tx_busy, .ir_rx_data);

// File: ldmc_blank_timer.sv
`timescale 1ns/100ps
// Stretches a busy level by count steps of one blanking unit each
module ldmc_blank_timer #(
	parameter int STEP_CYC = ldmc_pkg::TMO_STEP_CYC
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       busy,
	input  wire logic [7:0] steps,
	output logic            blank
);
	typedef struct packed {
		logic [15:0] cyc;
		logic [7:0]  stp;
		logic        act;
		logic        blank;
	} ldmc_bt_s;

	ldmc_bt_s st_reg, st_next;

	// Counter restarts while busy, then runs out the extension
	always_comb begin
		st_next = st_reg;
		if (busy) begin
			st_next.act = 1'b1;
			st_next.cyc = 16'h0000;
			st_next.stp = steps;
		end else if (st_reg.act) begin
			if (st_reg.stp == 8'h00) begin
				st_next.act = 1'b0;
			end else if (st_reg.cyc == 16'(STEP_CYC - 1)) begin
				st_next.cyc = 16'h0000;
				st_next.stp = st_reg.stp - 8'h01;
			end else begin
				st_next.cyc = st_reg.cyc + 16'h0001;
			end
		end
		st_next.blank = busy | st_next.act;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign blank = st_reg.blank;
endmodule

// File: ldmc_pkg.sv
package ldmc_pkg;
	// Logical device numbers
	localparam logic [7:0] LDN_PAR   = 8'h03;
	localparam logic [7:0] LDN_SER1  = 8'h04;
	localparam logic [7:0] LDN_SER2  = 8'h05;
	localparam logic [7:0] LDN_KBD   = 8'h07;
	// Register indices within a logical device
	localparam logic [7:0] IDX_F0    = 8'hF0;
	localparam logic [7:0] IDX_F1    = 8'hF1;
	localparam logic [7:0] IDX_F2    = 8'hF2;
	// APB byte addresses
	localparam logic [11:0] ADDR_LDN   = 12'h000;
	localparam logic [11:0] ADDR_INDEX = 12'h004;
	localparam logic [11:0] ADDR_DATA  = 12'h008;
	localparam logic [11:0] ADDR_SOFT  = 12'h00C;
	// Reset values
	localparam logic [7:0] RST_PAR_MODE  = 8'h3C;
	localparam logic [7:0] RST_PAR_ROUTE = 8'h00;
	localparam logic [7:0] RST_SER_MODE  = 8'h00;
	localparam logic [7:0] RST_IR_OPT    = 8'h02;
	localparam logic [7:0] RST_IR_TMO    = 8'h03;
	localparam logic [7:0] RST_KBD_GATE  = 8'h00;
	// Writable-bit masks; other bits read zero
	localparam logic [7:0] MASK_PAR_MODE  = 8'hFF;
	localparam logic [7:0] MASK_PAR_ROUTE = 8'h03;
	localparam logic [7:0] MASK_SER1_MODE = 8'h83;
	localparam logic [7:0] MASK_SER2_MODE = 8'h03;
	localparam logic [7:0] MASK_IR_OPT    = 8'h7F;
	localparam logic [7:0] MASK_KBD_GATE  = 8'h84;
	// Parallel port modes
	typedef enum logic [2:0] {
		LDMC_PM_SPP    = 3'h0,
		LDMC_PM_EPP19  = 3'h1,
		LDMC_PM_ECP    = 3'h2,
		LDMC_PM_ECPEPP = 3'h3,
		LDMC_PM_PRN    = 3'h4,
		LDMC_PM_EPP17  = 3'h5,
		LDMC_PM_RES    = 3'h6,
		LDMC_PM_ECP17  = 3'h7
	} ldmc_pmode_e;
	// ECP ecr sub-modes
	localparam logic [2:0] ECR_PRN  = 3'h0;
	localparam logic [2:0] ECR_SPP  = 3'h1;
	localparam logic [2:0] ECR_FIFO = 3'h2;
	localparam logic [2:0] ECR_ECP  = 3'h3;
	localparam logic [2:0] ECR_EPP  = 3'h4;
	localparam logic [2:0] ECR_TEST = 3'h6;
	// Infrared modes
	localparam logic [2:0] IR_STD  = 3'h0;
	localparam logic [2:0] IR_IRDA = 3'h1;
	localparam logic [2:0] IR_ASK  = 3'h2;
	// Timing
	localparam int CLK_MHZ      = 100;
	localparam int TMO_STEP_US  = 100;
	localparam int TMO_STEP_CYC = TMO_STEP_US * CLK_MHZ;
	localparam int PULSE_NS     = 100;
	localparam int PULSE_CYC    = (PULSE_NS * CLK_MHZ + 999) / 1000;
	// Interrupt pin drive bundle
	typedef struct packed {
		logic out;
		logic oe;
	} ldmc_pin_s;
endpackage

// File: ldmc_top.sv
`timescale 1ns/100ps
// Behaviour
// - Parallel mode field picks printer, SPP, EPP 1.9/1.7, ECP or ECP plus EPP.
// - Parallel mode bits 6:3 hold the ECP FIFO threshold, reset 0111.
// - Interrupt type one drives the parallel interrupt as a low pulse then released.
// - Interrupt type is ignored in printer and standard modes.
// - Interrupt type zero: interrupt follows acknowledge in EPP modes and in ECP printer, SPP and EPP sub-modes.
// - Interrupt is level type in ECP, test and FIFO sub-modes.
// - Floppy routing 00 normal, 01 drive one on parallel, 10 both on parallel.
// - Serial mode bit 0 enables MIDI, reset zero.
// - Serial mode bit 1 enables high speed, reset zero.
// - First serial mode bit 7 makes both ports share one interrupt.
// - Sharing with two assigned pins asserts both on either interrupt.
// - Infrared bit 0 inverts receive; bit 1 transmit polarity, reset active low.
// - Infrared bit 2 selects half duplex, reset full duplex.
// - Infrared mode 000 standard, 001 IrDA, 010 ASK; others reserved.
// - Infrared bit 6 routes traffic to second serial pins or alternate pins.
// - Half-duplex timeout extends blanking by value times 100 microseconds.
// - Keyboard gate bit 7 sets keyboard port bit output polarity, reset low.
// - Keyboard gate bit 2 enables the fast gate port.
// - Keyboard indices F1 to FF are reserved and read zero.
// - Registers reset only on power-on or hard reset, not soft reset; here soft reset clears the device number and index.
module ldmc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  ecr_mode,
	input  wire logic        printer_acknowledge_n,
	input  wire logic        par_irq_event,
	input  wire logic        ser1_irq,
	input  wire logic        ser2_irq,
	input  wire logic        ser1_pin_assigned,
	input  wire logic        ser2_pin_assigned,
	input  wire logic        ir_tx_data,
	input  wire logic        ir_tx_busy,
	input  wire logic        serial_two_receive_pin,
	input  wire logic        alt_infrared_receive_pin,
	input  wire logic        kbd_p12_raw,
	output logic             par_irq_out,
	output logic             par_irq_oe,
	output logic             floppy_routing_select,
	output logic             drive_one_on_printer_pins,
	output logic             both_drives_on_printer_pins,
	output logic      [2:0]  par_mode,
	output logic      [3:0]  ecp_fifo_threshold,
	output logic             ser1_midi_en,
	output logic             ser1_high_speed,
	output logic             ser2_midi_en,
	output logic             ser2_high_speed,
	output logic             ser1_irq_out,
	output logic             ser2_irq_out,
	output logic      [2:0]  ir_mode,
	output logic             ir_half_duplex,
	output logic             ir_rx_data,
	output logic             serial_two_transmit_pin,
	output logic             alt_infrared_transmit_pin,
	output logic             kbd_port_bit_one_two,
	output logic             fast_gate_port_en
);
	typedef struct packed {
		logic [7:0]  ldn;
		logic [7:0]  index;
		logic [7:0]  par_mode;
		logic [7:0]  par_route;
		logic [7:0]  ser1_mode;
		logic [7:0]  ser2_mode;
		logic [7:0]  ir_opt;
		logic [7:0]  ir_tmo;
		logic [7:0]  kbd_gate;
		logic [2:0]  route;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        ack_d;
		logic        ev_d;
		logic [3:0]  pulse_cnt;
		ldmc_pkg::ldmc_pin_s par_irq;
		logic        s1_irq;
		logic        s2_irq;
		logic        ir_rx;
		logic        tx2;
		logic        alt_tx;
		logic        p12;
	} ldmc_st_s;

	ldmc_st_s st_reg, st_next;
	logic     blank;

	// Half-duplex blanking extended by the timeout register
	ldmc_blank_timer #(
		.STEP_CYC (ldmc_pkg::TMO_STEP_CYC)
	) u_blank (
		.pclk    (pclk),
		.presetn (presetn),
		.busy    (ir_tx_busy),
		.steps   (st_reg.ir_tmo),
		.blank   (blank)
	);

	// Maps index in a logical device to its stored value; unmapped reads zero
	function automatic logic [7:0] read_reg(input ldmc_st_s s);
		logic [7:0] v;
		v = 8'h00;
		case (s.ldn)
			ldmc_pkg::LDN_PAR: begin
				if (s.index == ldmc_pkg::IDX_F0) v = s.par_mode;
				else if (s.index == ldmc_pkg::IDX_F1) v = s.par_route;
			end
			ldmc_pkg::LDN_SER1: begin
				if (s.index == ldmc_pkg::IDX_F0) v = s.ser1_mode;
			end
			ldmc_pkg::LDN_SER2: begin
				if (s.index == ldmc_pkg::IDX_F0) v = s.ser2_mode;
				else if (s.index == ldmc_pkg::IDX_F1) v = s.ir_opt;
				else if (s.index == ldmc_pkg::IDX_F2) v = s.ir_tmo;
			end
			ldmc_pkg::LDN_KBD: begin
				if (s.index == ldmc_pkg::IDX_F0) v = s.kbd_gate;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// True when the interrupt line follows the acknowledge input
	function automatic logic ack_follow(input logic [2:0] m, input logic [2:0] e);
		logic ecp;
		ecp = (m == ldmc_pkg::LDMC_PM_ECP) || (m == ldmc_pkg::LDMC_PM_ECPEPP) ||
		      (m == ldmc_pkg::LDMC_PM_ECP17);
		return ((m == ldmc_pkg::LDMC_PM_EPP19) || (m == ldmc_pkg::LDMC_PM_EPP17)) ||
		       (ecp && ((e == ldmc_pkg::ECR_PRN) || (e == ldmc_pkg::ECR_SPP) ||
		                (e == ldmc_pkg::ECR_EPP)));
	endfunction

	always_comb begin
		logic [7:0] wd;
		logic       wr;
		logic       rd;
		logic [2:0] pm;
		logic       ecp;
		logic       lvl;
		logic       rx_raw;
		logic       any_ser;
		wd      = pwdata[7:0];
		wr      = psel & penable & pwrite;
		rd      = psel & penable & ~pwrite;
		pm      = 3'h0;
		ecp     = 1'b0;
		lvl     = 1'b0;
		rx_raw  = 1'b0;
		any_ser = 1'b0;
		st_next = st_reg;
		st_next.pready  = psel & ~penable;
		st_next.pslverr = 1'b0;

		// APB: no wait state, answer in the cycle after setup
		if (psel && !penable) begin
			st_next.pslverr = (paddr > ldmc_pkg::ADDR_SOFT) || (paddr[1:0] != 2'b00);
			case (paddr)
				ldmc_pkg::ADDR_LDN:   st_next.prdata = {24'h000000, st_reg.ldn};
				ldmc_pkg::ADDR_INDEX: st_next.prdata = {24'h000000, st_reg.index};
				ldmc_pkg::ADDR_DATA:  st_next.prdata = {24'h000000, read_reg(st_reg)};
				default:              st_next.prdata = 32'h00000000;
			endcase
		end
		if (rd) begin
			st_next.prdata = st_reg.prdata;
		end
		if (wr && st_reg.pready) begin
			case (paddr)
				ldmc_pkg::ADDR_LDN:   st_next.ldn = wd;
				ldmc_pkg::ADDR_INDEX: st_next.index = wd;
				ldmc_pkg::ADDR_SOFT: begin
					// Soft reset returns only the selectors; mode registers keep value
					st_next.ldn   = 8'h00;
					st_next.index = 8'h00;
				end
				ldmc_pkg::ADDR_DATA: begin
					case (st_reg.ldn)
						ldmc_pkg::LDN_PAR: begin
							if (st_reg.index == ldmc_pkg::IDX_F0)
								st_next.par_mode = wd & ldmc_pkg::MASK_PAR_MODE;
							else if (st_reg.index == ldmc_pkg::IDX_F1)
								st_next.par_route = wd & ldmc_pkg::MASK_PAR_ROUTE;
						end
						ldmc_pkg::LDN_SER1: begin
							if (st_reg.index == ldmc_pkg::IDX_F0)
								st_next.ser1_mode = wd & ldmc_pkg::MASK_SER1_MODE;
						end
						ldmc_pkg::LDN_SER2: begin
							if (st_reg.index == ldmc_pkg::IDX_F0)
								st_next.ser2_mode = wd & ldmc_pkg::MASK_SER2_MODE;
							else if (st_reg.index == ldmc_pkg::IDX_F1)
								st_next.ir_opt = wd & ldmc_pkg::MASK_IR_OPT;
							else if (st_reg.index == ldmc_pkg::IDX_F2)
								st_next.ir_tmo = wd;
						end
						ldmc_pkg::LDN_KBD: begin
							if (st_reg.index == ldmc_pkg::IDX_F0)
								st_next.kbd_gate = wd & ldmc_pkg::MASK_KBD_GATE;
						end
						default: st_next.ldn = st_reg.ldn;
					endcase
				end
				default: st_next.ldn = st_reg.ldn;
			endcase
		end

		// Routing decode is registered so the routing pins come straight from flops
		st_next.route = {st_next.par_route[1:0] == 2'b10, st_next.par_route[1:0] == 2'b01,
		                 st_next.par_route[1:0] != 2'b00};

		// Parallel interrupt style
		pm  = st_reg.par_mode[2:0];
		ecp = (pm == ldmc_pkg::LDMC_PM_ECP) || (pm == ldmc_pkg::LDMC_PM_ECPEPP) ||
		      (pm == ldmc_pkg::LDMC_PM_ECP17);
		lvl = ecp && ((ecr_mode == ldmc_pkg::ECR_ECP) || (ecr_mode == ldmc_pkg::ECR_TEST) ||
		              (ecr_mode == ldmc_pkg::ECR_FIFO));
		st_next.ack_d = printer_acknowledge_n;
		st_next.ev_d  = par_irq_event;
		if (lvl) begin
			st_next.par_irq   = '{out: par_irq_event, oe: 1'b1};
			st_next.pulse_cnt = 4'h0;
		end else if (st_reg.par_mode[7] && pm != ldmc_pkg::LDMC_PM_PRN &&
		             pm != ldmc_pkg::LDMC_PM_SPP) begin
			// Pulse low on acknowledge falling, then release the line
			if (st_reg.ack_d && !printer_acknowledge_n) begin
				st_next.pulse_cnt = 4'(ldmc_pkg::PULSE_CYC);
			end else if (st_reg.pulse_cnt != 4'h0) begin
				st_next.pulse_cnt = st_reg.pulse_cnt - 4'h1;
			end
			st_next.par_irq = '{out: 1'b0, oe: (st_next.pulse_cnt != 4'h0)};
		end else if (ack_follow(pm, ecr_mode)) begin
			st_next.par_irq   = '{out: printer_acknowledge_n, oe: 1'b1};
			st_next.pulse_cnt = 4'h0;
		end else begin
			// Printer and standard modes drive the plain event level
			st_next.par_irq   = '{out: par_irq_event, oe: 1'b1};
			st_next.pulse_cnt = 4'h0;
		end

		// Serial interrupt sharing
		any_ser = ser1_irq | ser2_irq;
		if (st_reg.ser1_mode[7]) begin
			st_next.s1_irq = any_ser & ser1_pin_assigned;
			st_next.s2_irq = any_ser & ser2_pin_assigned;
		end else begin
			st_next.s1_irq = ser1_irq;
			st_next.s2_irq = ser2_irq;
		end

		// Infrared path: location, polarity, blanking
		rx_raw = st_reg.ir_opt[6] ? alt_infrared_receive_pin : serial_two_receive_pin;
		st_next.ir_rx = (rx_raw ^ st_reg.ir_opt[0]) & ~(st_reg.ir_opt[2] & blank);
		if (st_reg.ir_opt[5:3] == ldmc_pkg::IR_STD) begin
			st_next.tx2    = ir_tx_data;
			st_next.alt_tx = 1'b0;
		end else if (st_reg.ir_opt[6]) begin
			st_next.tx2    = 1'b1;
			st_next.alt_tx = ir_tx_data ^ st_reg.ir_opt[1];
		end else begin
			st_next.tx2    = ir_tx_data ^ st_reg.ir_opt[1];
			st_next.alt_tx = 1'b0;
		end

		// Keyboard port bit polarity
		st_next.p12 = st_reg.kbd_gate[7] ? kbd_p12_raw : ~kbd_p12_raw;
	end

	// Power-on or hard reset restores defaults; soft reset returns only ldn and index to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg           <= '0;
			st_reg.par_mode  <= ldmc_pkg::RST_PAR_MODE;
			st_reg.par_route <= ldmc_pkg::RST_PAR_ROUTE;
			st_reg.ser1_mode <= ldmc_pkg::RST_SER_MODE;
			st_reg.ser2_mode <= ldmc_pkg::RST_SER_MODE;
			st_reg.ir_opt    <= ldmc_pkg::RST_IR_OPT;
			st_reg.ir_tmo    <= ldmc_pkg::RST_IR_TMO;
			st_reg.kbd_gate  <= ldmc_pkg::RST_KBD_GATE;
			st_reg.par_irq   <= '{out: 1'b1, oe: 1'b0};
			st_reg.ack_d     <= 1'b1;
			st_reg.p12       <= 1'b1;
			st_reg.tx2       <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs from state flip-flops
	assign prdata                      = st_reg.prdata;
	assign pready                      = st_reg.pready;
	assign pslverr                     = st_reg.pslverr;
	assign par_irq_out                 = st_reg.par_irq.out;
	assign par_irq_oe                  = st_reg.par_irq.oe;
	assign floppy_routing_select       = st_reg.route[0];
	assign drive_one_on_printer_pins   = st_reg.route[1];
	assign both_drives_on_printer_pins = st_reg.route[2];
	assign par_mode                    = st_reg.par_mode[2:0];
	assign ecp_fifo_threshold          = st_reg.par_mode[6:3];
	assign ser1_midi_en                = st_reg.ser1_mode[0];
	assign ser1_high_speed             = st_reg.ser1_mode[1];
	assign ser2_midi_en                = st_reg.ser2_mode[0];
	assign ser2_high_speed             = st_reg.ser2_mode[1];
	assign ser1_irq_out                = st_reg.s1_irq;
	assign ser2_irq_out                = st_reg.s2_irq;
	assign ir_mode                     = st_reg.ir_opt[5:3];
	assign ir_half_duplex              = st_reg.ir_opt[2];
	assign ir_rx_data                  = st_reg.ir_rx;
	assign serial_two_transmit_pin     = st_reg.tx2;
	assign alt_infrared_transmit_pin   = st_reg.alt_tx;
	assign kbd_port_bit_one_two        = st_reg.p12;
	assign fast_gate_port_en           = st_reg.kbd_gate[2];
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the logical device config bank
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0]  ecr_mode, par_mode, ir_mode;
	logic [3:0]  ecp_fifo_threshold;
	logic        printer_acknowledge_n, par_irq_event, ser1_irq, ser2_irq, ser1_pin_assigned, ser2_pin_assigned;
	logic        ir_tx_data, ir_tx_busy, serial_two_receive_pin, alt_infrared_receive_pin, kbd_p12_raw;
	logic        par_irq_out, par_irq_oe, floppy_routing_select, drive_one_on_printer_pins;
	logic        both_drives_on_printer_pins, ser1_midi_en, ser1_high_speed, ser2_midi_en, ser2_high_speed;
	logic        ser1_irq_out, ser2_irq_out, ir_half_duplex, ir_rx_data, serial_two_transmit_pin;
	logic        alt_infrared_transmit_pin, kbd_port_bit_one_two, fast_gate_port_en;
	int          err_count, checked, seed;
	logic [7:0]  rd;
	logic [7:0]  wv[7];
	// Register table: device, index, reset value, bits that hold data
	logic [7:0]  t_ldn[7] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h03, 8'h05, 8'h05};
	logic [7:0]  t_idx[7] = '{8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF1, 8'hF1, 8'hF2};
	logic [7:0]  t_rst[7] = '{8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03};
	logic [7:0]  t_msk[7] = '{8'hFF, 8'h83, 8'h03, 8'h84, 8'h03, 8'h7F, 8'hFF};

	ldmc_top u_dut (.*);

	// 100 MHz clock
	always #5 pclk = ~pclk;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	// One APB transfer; request held until pready is sampled, so no wait count is assumed
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata[7:0];
		se = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Indirect access: device number, index, then data
	task automatic cfg(input logic w, input logic [7:0] l, input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, ldmc_pkg::ADDR_LDN, l);
		apb(1'b1, ldmc_pkg::ADDR_INDEX, i);
		apb(w, ldmc_pkg::ADDR_DATA, d);
	endtask

	task automatic summarize;
		if (err_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Watchdog well above the expected run length
	initial begin
		repeat (60000) @(posedge pclk);
		err_count++;
		summarize();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, ecr_mode, par_irq_event} = '0;
		{ser1_irq, ser2_irq, ser1_pin_assigned, ser2_pin_assigned, ir_tx_data, ir_tx_busy} = '0;
		{serial_two_receive_pin, alt_infrared_receive_pin, kbd_p12_raw} = '0;
		printer_acknowledge_n = 1'b1;
		seed = 32'h30ebe720;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Defaults after hard reset
		for (int k = 0; k < 7; k++) begin
			cfg(1'b0, t_ldn[k], t_idx[k], 8'h00);
			chk("reset value", t_rst[k], rd);
		end
		chk("par_mode", 3'h4, par_mode);
		chk("fifo threshold", 4'h7, ecp_fifo_threshold);
		// Random fill of all registers; shared indices must not alias, reserved bits read zero
		for (int n = 0; n < 12; n++) begin
			for (int k = 0; k < 7; k++) begin
				wv[k] = 8'($random(seed));
				if (k == 4) wv[k][1:0] = 2'(n % 3);
				if (k == 1 || k == 2 || k == 5) wv[k] = wv[k] & t_msk[k];
				cfg(1'b1, t_ldn[k], t_idx[k], wv[k]);
			end
			for (int k = 0; k < 7; k++) begin
				cfg(1'b0, t_ldn[k], t_idx[k], 8'h00);
				chk("readback", wv[k] & t_msk[k], rd);
			end
			chk("par_mode", wv[0][2:0], par_mode);
			chk("fifo threshold", wv[0][6:3], ecp_fifo_threshold);
			chk("ser1 midi", wv[1][0], ser1_midi_en);
			chk("ser2 speed", wv[2][1], ser2_high_speed);
			chk("ser1 speed", wv[1][1], ser1_high_speed);
			chk("ser2 midi", wv[2][0], ser2_midi_en);
			chk("fast gate", wv[3][2], fast_gate_port_en);
			chk("route one", wv[4][1:0] == 2'h1, drive_one_on_printer_pins);
			chk("route both", wv[4][1:0] == 2'h2, both_drives_on_printer_pins);
			chk("route select", wv[4][1:0] != 2'h0, floppy_routing_select);
			chk("ir duplex", wv[5][2], ir_half_duplex);
			chk("ir mode", wv[5][5:3], ir_mode);
		end
		// Soft reset leaves the bank alone; unmapped and unaligned addresses are refused
		apb(1'b1, ldmc_pkg::ADDR_SOFT, 8'h00);
		cfg(1'b0, 8'h03, 8'hF0, 8'h00);
		chk("after soft reset", wv[0], rd);
		chk("mapped slverr", 1'b0, se);
		apb(1'b0, 12'h010, 8'h00);
		chk("unmapped slverr", 1'b1, se);
		apb(1'b1, 12'h006, 8'h00);
		chk("unaligned slverr", 1'b1, se);
		for (int i = 8'hF1; i <= 8'hFF; i++) begin
			cfg(1'b1, 8'h07, 8'(i), 8'hFF);
			cfg(1'b0, 8'h07, 8'(i), 8'h00);
			chk("kbd reserved", 8'h00, rd);
		end
		// Keyboard bit polarity, both settings and both levels
		for (int m = 0; m < 4; m++) begin
			cfg(1'b1, 8'h07, 8'hF0, {m[1], 7'h00});
			kbd_p12_raw <= m[0];
			repeat (3) @(posedge pclk);
			chk("kbd p12", m[1] ? m[0] : !m[0], kbd_port_bit_one_two);
		end
		// Irq sharing: s[0] share bit, s[1] port two left without a pin, s[2] port one raises
		ser1_pin_assigned <= 1'b1;
		for (int s = 0; s < 8; s++) begin
			ser2_pin_assigned <= !s[1];
			cfg(1'b1, 8'h04, 8'hF0, {s[0], 7'h00});
			ser1_irq <= s[2];
			ser2_irq <= !s[2];
			repeat (3) @(posedge pclk);
			chk("ser1 irq", s[0] ? 1'b1 : s[2], ser1_irq_out);
			chk("ser2 irq", s[0] ? !s[1] : !s[2], ser2_irq_out);
			ser1_irq <= 1'b0;
			ser2_irq <= 1'b0;
		end
		// Infrared receive polarity and pin location, full duplex
		serial_two_receive_pin <= 1'b1;
		ir_tx_data             <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			cfg(1'b1, 8'h05, 8'hF1, {1'b0, m[1], 4'h2, m[0], m[0]});
			repeat (3) @(posedge pclk);
			chk("ir rx", !m[1] ^ m[0], ir_rx_data);
			chk("ir tx alt", m[1] ? !m[0] : 1'b0, alt_infrared_transmit_pin);
			chk("ir tx2", m[1] ? 1'b1 : !m[0], serial_two_transmit_pin);
		end
		// Half duplex blanking stretched by one 100 us step
		cfg(1'b1, 8'h05, 8'hF2, 8'h01);
		cfg(1'b1, 8'h05, 8'hF1, 8'h0C);
		ir_tx_busy <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("blank busy", 1'b0, ir_rx_data);
		ir_tx_busy <= 1'b0;
		repeat (9000) @(posedge pclk);
		chk("blank stretched", 1'b0, ir_rx_data);
		repeat (1200) @(posedge pclk);
		chk("blank over", 1'b1, ir_rx_data);
		// Parallel irq in EPP: level follows acknowledge, then pulsed low and released
		cfg(1'b1, 8'h03, 8'hF0, 8'h01);
		printer_acknowledge_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("irq follows ack", 1'b0, par_irq_out);
		printer_acknowledge_n <= 1'b1;
		cfg(1'b1, 8'h03, 8'hF0, 8'h81);
		printer_acknowledge_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("pulse driven", 1'b1, par_irq_oe);
		chk("pulse low", 1'b0, par_irq_out);
		repeat (12) @(posedge pclk);
		chk("pulse released", 1'b0, par_irq_oe);
		// Level style in the ECP FIFO sub-mode; type bit ignored in printer mode
		for (int m = 0; m < 2; m++) begin
			printer_acknowledge_n <= 1'b1;
			par_irq_event         <= 1'b1;
			ecr_mode              <= ldmc_pkg::ECR_FIFO;
			cfg(1'b1, 8'h03, 8'hF0, m ? 8'h84 : 8'h82);
			printer_acknowledge_n <= 1'b0;
			repeat (3) @(posedge pclk);
			chk("irq level", 1'b1, par_irq_out);
			chk("irq level oe", 1'b1, par_irq_oe);
		end
		summarize();
	end
endmodule
